// File: rcc_axil_slave.sv
// Purpose: AXI4-Lite slave turning handshakes into register strobes
// Assumes: One write and one read outstanding at most
// Notes:   Address and data are taken in either order; all AXI outputs are flops
`timescale 1ns/1ps
module rcc_axil_slave (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Write address and data
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [rcc_pkg::RCC_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [rcc_pkg::RCC_DATA_W-1:0] i_wdata,
    input wire logic [rcc_pkg::RCC_STRB_W-1:0] i_wstrb,
    // Write response
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // Read address and data
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [rcc_pkg::RCC_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [rcc_pkg::RCC_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    // Register side
    rcc_regbus_if.bus regbus
);
    typedef struct packed {
        logic aw_held;
        logic [rcc_pkg::RCC_ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [rcc_pkg::RCC_DATA_W-1:0] w_data;
        logic [rcc_pkg::RCC_STRB_W-1:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [rcc_pkg::RCC_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } rcc_axil_state_t;

    rcc_axil_state_t state_r;
    rcc_axil_state_t state_nxt;

    // Write fires once both halves are held and no response is pending
    assign regbus.wr_en = state_r.aw_held & state_r.w_held & ~state_r.bvalid;
    assign regbus.wr_addr = state_r.aw_addr;
    assign regbus.wr_data = state_r.w_data;
    assign regbus.wr_strb = state_r.w_strb;
    // Read looks up the live address in the accepting cycle
    assign regbus.rd_en = state_r.arready & i_arvalid;
    assign regbus.rd_addr = i_araddr;

    // Handshake sequencing
    always_comb begin
        state_nxt = state_r;
        if (state_r.bvalid && i_bready) begin
            state_nxt.bvalid = 1'b0;
        end
        if (state_r.rvalid && i_rready) begin
            state_nxt.rvalid = 1'b0;
        end
        if (state_r.awready && i_awvalid) begin
            state_nxt.aw_held = 1'b1;
            state_nxt.aw_addr = i_awaddr;
        end
        if (state_r.wready && i_wvalid) begin
            state_nxt.w_held = 1'b1;
            state_nxt.w_data = i_wdata;
            state_nxt.w_strb = i_wstrb;
        end
        if (regbus.wr_en) begin
            state_nxt.aw_held = 1'b0;
            state_nxt.w_held = 1'b0;
            state_nxt.bvalid = 1'b1;
            state_nxt.bresp = regbus.wr_ok ? rcc_pkg::RCC_RESP_OKAY : rcc_pkg::RCC_RESP_SLVERR;
        end
        if (regbus.rd_en) begin
            state_nxt.rvalid = 1'b1;
            state_nxt.rdata = regbus.rd_data;
            state_nxt.rresp = regbus.rd_ok ? rcc_pkg::RCC_RESP_OKAY : rcc_pkg::RCC_RESP_SLVERR;
        end
        // Readies are registered so no AXI output is combinational
        state_nxt.awready = ~state_nxt.aw_held & ~state_nxt.bvalid;
        state_nxt.wready = ~state_nxt.w_held & ~state_nxt.bvalid;
        state_nxt.arready = ~state_nxt.rvalid;
    end

    // State register
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_awready = state_r.awready;
    assign o_wready = state_r.wready;
    assign o_bvalid = state_r.bvalid;
    assign o_bresp = state_r.bresp;
    assign o_arready = state_r.arready;
    assign o_rvalid = state_r.rvalid;
    assign o_rdata = state_r.rdata;
    assign o_rresp = state_r.rresp;
endmodule

// File: rcc_pkg.sv
// Purpose: Shared constants for the reset cause status block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Offsets are byte addresses; masks are built from bit positions
package rcc_pkg;

    // Bus geometry
    localparam int unsigned RCC_DATA_W = 32;
    localparam int unsigned RCC_STRB_W = RCC_DATA_W / 8;
    localparam int unsigned RCC_ADDR_W = 12;

    // Register byte offsets
    localparam logic [RCC_ADDR_W-1:0] RCC_OFS_CONTROL = 12'h000;
    localparam logic [RCC_ADDR_W-1:0] RCC_OFS_IRQ_STATUS = 12'h004;
    localparam logic [RCC_ADDR_W-1:0] RCC_OFS_IRQ_CLEAR = 12'h008;
    localparam logic [RCC_ADDR_W-1:0] RCC_OFS_IRQ_ENABLE = 12'h00c;

    // Field positions in reset_cause_control
    localparam int unsigned RCC_BIT_OVERVOLTAGE = 29;
    localparam int unsigned RCC_BIT_CONFIG_MISMATCH = 9;
    localparam int unsigned RCC_BIT_KEEP_ON = 8;
    localparam int unsigned RCC_BIT_PIN_RESET = 7;
    localparam int unsigned RCC_BIT_SOFT_RESET = 6;
    localparam int unsigned RCC_BIT_WATCHDOG = 4;
    localparam int unsigned RCC_BIT_SLEEP_WAKE = 3;
    localparam int unsigned RCC_BIT_IDLE_WAKE = 2;
    localparam int unsigned RCC_BIT_BROWNOUT = 1;
    localparam int unsigned RCC_BIT_POWER_ON = 0;

    // Hardware-set flags only
    localparam logic [RCC_DATA_W-1:0] RCC_FLAG_MASK =
        (32'h1 << RCC_BIT_OVERVOLTAGE) | (32'h1 << RCC_BIT_CONFIG_MISMATCH) |
        (32'h1 << RCC_BIT_PIN_RESET) | (32'h1 << RCC_BIT_SOFT_RESET) |
        (32'h1 << RCC_BIT_WATCHDOG) | (32'h1 << RCC_BIT_SLEEP_WAKE) |
        (32'h1 << RCC_BIT_IDLE_WAKE) | (32'h1 << RCC_BIT_BROWNOUT) |
        (32'h1 << RCC_BIT_POWER_ON);

    // All implemented control bits
    localparam logic [RCC_DATA_W-1:0] RCC_IMPL_MASK =
        RCC_FLAG_MASK | (32'h1 << RCC_BIT_KEEP_ON);

    // Values after power-on reset
    localparam logic [RCC_DATA_W-1:0] RCC_CONTROL_RESET =
        (32'h1 << RCC_BIT_BROWNOUT) | (32'h1 << RCC_BIT_POWER_ON);
    localparam logic [RCC_DATA_W-1:0] RCC_IRQ_STATUS_RESET = 32'h0000_0000;
    localparam logic [RCC_DATA_W-1:0] RCC_IRQ_ENABLE_RESET = 32'h0000_0000;
    localparam logic RCC_REG_EN_RESET = 1'b1;

    // AXI response codes
    localparam logic [1:0] RCC_RESP_OKAY = 2'h0;
    localparam logic [1:0] RCC_RESP_SLVERR = 2'h2;

endpackage

// File: rcc_regbus_if.sv
// Purpose: Register access strobes between bus slave and register file
// Assumes: Single clock domain, combinational decode on the register side
// Notes:   rd_data and ok flags answer in the same cycle as the address
`timescale 1ns/1ps
interface rcc_regbus_if;
    logic wr_en;
    logic [rcc_pkg::RCC_ADDR_W-1:0] wr_addr;
    logic [rcc_pkg::RCC_DATA_W-1:0] wr_data;
    logic [rcc_pkg::RCC_STRB_W-1:0] wr_strb;
    logic wr_ok;
    logic rd_en;
    logic [rcc_pkg::RCC_ADDR_W-1:0] rd_addr;
    logic [rcc_pkg::RCC_DATA_W-1:0] rd_data;
    logic rd_ok;

    modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        input wr_ok, rd_data, rd_ok);
    modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
        output wr_ok, rd_data, rd_ok);
endinterface

// File: rcc_top.sv
// Purpose: Reset cause flags, regulator sleep control and cause interrupt
// Assumes: i_srst is the power-on reset; event pulses are on i_sys_clk
// Notes:   Later resets of the chip arrive as events, not as i_srst
//
// Summary of operation
// - Overvoltage reset event sets flag bit 29.
// - Configuration mismatch reset event sets flag bit 9.
// - Bit 8 read/write, resets zero; 1 keeps regulator on in sleep.
// - Master clear pin reset sets flag bit 7.
// - Software reset sets flag bit 6.
// - Watchdog time-out sets flag bit 4.
// - Wake from sleep sets flag bit 3.
// - Wake from idle sets flag bit 2.
// - Brown-out sets flag bit 1; reads 1 after power-on reset.
// - Power-on reset sets flag bit 0; reads 1 after power-on.
// - Bits 31-30, 28-10 and 5 read zero and ignore writes.
// - Software may read and overwrite every flag.
`timescale 1ns/1ps
module rcc_top #(
    parameter int unsigned ADDR_W = rcc_pkg::RCC_ADDR_W
) (
    // Clock and power-on reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Reset and wake events, one-cycle pulses
    input wire logic i_overvoltage_evt,
    input wire logic i_config_mismatch_evt,
    input wire logic i_pin_reset_evt,
    input wire logic i_soft_reset_evt,
    input wire logic i_watchdog_evt,
    input wire logic i_sleep_wake_evt,
    input wire logic i_idle_wake_evt,
    input wire logic i_brownout_evt,
    // Power state from the power manager
    input wire logic i_sleep_mode,
    // Regulator control and interrupt
    output logic o_regulator_sleep_keep_on,
    output logic o_regulator_en,
    output logic o_irq,
    // AXI4-Lite write channels
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [rcc_pkg::RCC_DATA_W-1:0] i_wdata,
    input wire logic [rcc_pkg::RCC_STRB_W-1:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    // AXI4-Lite read channels
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [rcc_pkg::RCC_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp
);
    // The decode is fixed to the package address width
    if (ADDR_W != rcc_pkg::RCC_ADDR_W) begin : g_bad_addr_w
        $error("rcc_top: ADDR_W must equal the package address width");
    end

    typedef struct packed {
        logic [rcc_pkg::RCC_DATA_W-1:0] control;
        logic [rcc_pkg::RCC_DATA_W-1:0] irq_status;
        logic [rcc_pkg::RCC_DATA_W-1:0] irq_enable;
        logic regulator_en;
        logic irq;
    } rcc_state_t;

    rcc_state_t state_r;
    rcc_state_t state_nxt;
    logic [rcc_pkg::RCC_DATA_W-1:0] hw_set;
    logic [rcc_pkg::RCC_DATA_W-1:0] byte_mask;
    logic [rcc_pkg::RCC_DATA_W-1:0] ctrl_wmask;
    logic [rcc_pkg::RCC_DATA_W-1:0] clr_mask;
    logic [rcc_pkg::RCC_DATA_W-1:0] en_wmask;

    rcc_regbus_if regbus ();

    // Bus slave
    rcc_axil_slave u_slave (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .regbus(regbus.bus)
    );

    // Gather event pulses into the flag layout
    always_comb begin
        hw_set = '0;
        hw_set[rcc_pkg::RCC_BIT_OVERVOLTAGE] = i_overvoltage_evt;
        hw_set[rcc_pkg::RCC_BIT_CONFIG_MISMATCH] = i_config_mismatch_evt;
        hw_set[rcc_pkg::RCC_BIT_PIN_RESET] = i_pin_reset_evt;
        hw_set[rcc_pkg::RCC_BIT_SOFT_RESET] = i_soft_reset_evt;
        hw_set[rcc_pkg::RCC_BIT_WATCHDOG] = i_watchdog_evt;
        hw_set[rcc_pkg::RCC_BIT_SLEEP_WAKE] = i_sleep_wake_evt;
        hw_set[rcc_pkg::RCC_BIT_IDLE_WAKE] = i_idle_wake_evt;
        hw_set[rcc_pkg::RCC_BIT_BROWNOUT] = i_brownout_evt;
    end

    // Expand byte strobes to a bit mask
    always_comb begin
        for (int i = 0; i < rcc_pkg::RCC_STRB_W; i++) begin
            byte_mask[i*8 +: 8] = {8{regbus.wr_strb[i]}};
        end
    end

    // Per-register write masks; unimplemented bits never take data
    always_comb begin
        ctrl_wmask = '0;
        clr_mask = '0;
        en_wmask = '0;
        if (regbus.wr_en) begin
            case (regbus.wr_addr)
                rcc_pkg::RCC_OFS_CONTROL: begin
                    ctrl_wmask = byte_mask & rcc_pkg::RCC_IMPL_MASK;
                end
                rcc_pkg::RCC_OFS_IRQ_CLEAR: begin
                    clr_mask = byte_mask & regbus.wr_data & rcc_pkg::RCC_FLAG_MASK;
                end
                rcc_pkg::RCC_OFS_IRQ_ENABLE: begin
                    en_wmask = byte_mask & rcc_pkg::RCC_FLAG_MASK;
                end
                default: begin
                    ctrl_wmask = '0;
                end
            endcase
        end
    end

    // Write decode answer
    always_comb begin
        case (regbus.wr_addr)
            rcc_pkg::RCC_OFS_CONTROL,
            rcc_pkg::RCC_OFS_IRQ_STATUS,
            rcc_pkg::RCC_OFS_IRQ_CLEAR,
            rcc_pkg::RCC_OFS_IRQ_ENABLE: begin
                regbus.wr_ok = 1'b1;
            end
            default: begin
                regbus.wr_ok = 1'b0;
            end
        endcase
    end

    // Read mux; the clear register reads zero
    always_comb begin
        regbus.rd_data = '0;
        regbus.rd_ok = 1'b1;
        case (regbus.rd_addr)
            rcc_pkg::RCC_OFS_CONTROL: begin
                regbus.rd_data = state_r.control & rcc_pkg::RCC_IMPL_MASK;
            end
            rcc_pkg::RCC_OFS_IRQ_STATUS: begin
                regbus.rd_data = state_r.irq_status;
            end
            rcc_pkg::RCC_OFS_IRQ_CLEAR: begin
                regbus.rd_data = '0;
            end
            rcc_pkg::RCC_OFS_IRQ_ENABLE: begin
                regbus.rd_data = state_r.irq_enable;
            end
            default: begin
                regbus.rd_ok = 1'b0;
            end
        endcase
    end

    // Next state of flags, interrupt and regulator
    always_comb begin
        state_nxt = state_r;
        state_nxt.control = (state_r.control & ~ctrl_wmask) | (regbus.wr_data & ctrl_wmask);
        state_nxt.control = state_nxt.control | hw_set;
        // Status write-one-to-clear, set wins the same cycle
        state_nxt.irq_status = (state_r.irq_status & ~clr_mask) | hw_set;
        state_nxt.irq_enable = (state_r.irq_enable & ~en_wmask) | (regbus.wr_data & en_wmask);
        state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_enable);
        state_nxt.regulator_en = ~i_sleep_mode | state_nxt.control[rcc_pkg::RCC_BIT_KEEP_ON];
    end

    // State register; only power-on reset reinitialises the flags
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            state_r.control <= rcc_pkg::RCC_CONTROL_RESET;
            state_r.irq_status <= rcc_pkg::RCC_IRQ_STATUS_RESET;
            state_r.irq_enable <= rcc_pkg::RCC_IRQ_ENABLE_RESET;
            state_r.regulator_en <= rcc_pkg::RCC_REG_EN_RESET;
            state_r.irq <= 1'b0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign o_regulator_sleep_keep_on = state_r.control[rcc_pkg::RCC_BIT_KEEP_ON];
    assign o_regulator_en = state_r.regulator_en;
    assign o_irq = state_r.irq;
endmodule

// File: rcc_top_props.sv
// Purpose: Port-level timing checks for the reset cause block
// Assumes: One clock, i_srst synchronous and active high
// Notes:   Bound to rcc_top from the testbench top file
`timescale 1ns/1ps
module rcc_top_props #(
    parameter int unsigned ADDR_W = 12
) (
    // Clock, reset and power state
    input wire logic i_sys_clk, i_srst, i_sleep_mode,
    // Regulator and interrupt outputs
    input wire logic o_regulator_sleep_keep_on, o_regulator_en, o_irq,
    // Bus handshakes
    input wire logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready,
    input wire logic i_arvalid, o_arready, o_rvalid, i_rready,
    input wire logic [1:0] o_bresp, o_rresp,
    input wire logic [31:0] o_rdata
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    // Write taken with both halves on one edge, answered two edges later
    sequence s_wr_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_b_answer;
        !o_bvalid ##1 o_bvalid;
    endsequence

    a_write_answer: assert property (s_wr_taken |=> s_b_answer)
        else $error("write response not two cycles after taken");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read data not one cycle after address");
    a_b_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped before taken");
    a_r_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped or changed before taken");
    a_wr_refuse: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("write accepted while response pending");
    a_rd_refuse: assert property (o_rvalid |-> !o_arready)
        else $error("read accepted while data pending");
    a_rsvd_zero: assert property (o_rvalid |-> (o_rdata & ~rcc_pkg::RCC_IMPL_MASK) == '0)
        else $error("unimplemented bit read as one");
    a_err_data: assert property (o_rvalid && o_rresp == rcc_pkg::RCC_RESP_SLVERR
        |-> o_rdata == '0) else $error("error read returned data");
    // Enable uses the keep-on bit landing on the same edge, sleep from one edge back
    a_regen_follow: assert property (!$past(i_srst) |-> o_regulator_en ==
        (!$past(i_sleep_mode) || o_regulator_sleep_keep_on))
        else $error("regulator enable wrong for sleep and keep-on");
    a_irq_drop: assert property ($fell(o_irq) |-> $rose(o_bvalid))
        else $error("interrupt fell without a register write");
endmodule

// File: rcc_top_tb.sv
// Purpose: Self-checking bench for reset cause flags, regulator and irq
// Assumes: AXI4-Lite master tasks; events are one-cycle pulses
// Notes:   An event held across a clearing write checks set over clear
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module rcc_top_tb;
    // Design ports, all driven from time zero
    logic i_sys_clk = 1'b0, i_srst = 1'b1, i_sleep_mode = 1'b0;
    logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
    logic i_arvalid = 1'b0, i_rready = 1'b0;
    logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [3:0] i_wstrb = 4'h0;
    logic [1:0] o_bresp, o_rresp;
    logic o_regulator_sleep_keep_on, o_regulator_en, o_irq;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic i_overvoltage_evt, i_config_mismatch_evt, i_pin_reset_evt, i_soft_reset_evt;
    logic i_watchdog_evt, i_sleep_wake_evt, i_idle_wake_evt, i_brownout_evt;
    logic [0:7] evt = 8'h00;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    // Flag bit set by each event line, in evt order
    int unsigned ev_bit [8] = '{29, 9, 7, 6, 4, 3, 2, 1};

    // Event lines in one vector so scenarios can loop over them
    assign {i_overvoltage_evt, i_config_mismatch_evt, i_pin_reset_evt, i_soft_reset_evt,
        i_watchdog_evt, i_sleep_wake_evt, i_idle_wake_evt, i_brownout_evt} = evt;

    rcc_top #(.ADDR_W(12)) u_dut (.*);

    // 125 MHz clock
    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    // Hang guard, well above the few hundred cycles needed
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Write one word; address and data offered together, each released when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        bit a_ok = 0;
        bit w_ok = 0;
        @(posedge i_sys_clk);
        i_awvalid <= 1'b1;
        i_awaddr <= a;
        i_wvalid <= 1'b1;
        i_wdata <= d;
        i_wstrb <= 4'hf;
        i_bready <= 1'b1;
        while (!(a_ok && w_ok)) begin
            @(posedge i_sys_clk);
            if (!a_ok && o_awready === 1'b1) begin
                a_ok = 1;
                i_awvalid <= 1'b0;
            end
            if (!w_ok && o_wready === 1'b1) begin
                w_ok = 1;
                i_wvalid <= 1'b0;
            end
        end
        while (o_bvalid !== 1'b1) @(posedge i_sys_clk);
        r = o_bresp;
        i_bready <= 1'b0;
    endtask

    // Read one word; rready held until data is seen
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_sys_clk);
        i_arvalid <= 1'b1;
        i_araddr <= a;
        i_rready <= 1'b1;
        do @(posedge i_sys_clk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_sys_clk); while (o_rvalid !== 1'b1);
        d = o_rdata;
        r = o_rresp;
        i_rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        `CHK("read data", e, d)
        `CHK("read resp", rcc_pkg::RCC_RESP_OKAY, r)
    endtask

    task automatic wrok(input logic [11:0] a, input logic [31:0] d);
        logic [1:0] r;
        wr(a, d, r);
        `CHK("write resp", rcc_pkg::RCC_RESP_OKAY, r)
    endtask

    task automatic pulse(input int k);
        @(posedge i_sys_clk);
        evt[k] <= 1'b1;
        @(posedge i_sys_clk);
        evt[k] <= 1'b0;
    endtask

    // Power-on values, also used as a reset at the end of the run
    task automatic t_reset;
        @(posedge i_sys_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        @(negedge i_sys_clk);
        `CHK("keep_on", 1'b0, o_regulator_sleep_keep_on)
        `CHK("regulator_en", 1'b1, o_regulator_en)
        `CHK("irq", 1'b0, o_irq)
        rdchk(rcc_pkg::RCC_OFS_CONTROL, 32'h0000_0003);
        rdchk(rcc_pkg::RCC_OFS_IRQ_ENABLE, 32'h0000_0000);
    endtask

    // Each event sets only its own flag; flags then accumulate
    task automatic t_events;
        for (int k = 0; k < 8; k++) begin
            // software clears flags before the next event
            wrok(rcc_pkg::RCC_OFS_CONTROL, 32'h0000_0000);
            pulse(k);
            rdchk(rcc_pkg::RCC_OFS_CONTROL, 32'h1 << ev_bit[k]);
        end
        pulse(0);
        pulse(7);
        rdchk(rcc_pkg::RCC_OFS_CONTROL, 32'h2000_0002);
        // Overvoltage held high across a clearing write; the set must win
        evt[0] <= 1'b1;
        wrok(rcc_pkg::RCC_OFS_CONTROL, 32'h0000_0000);
        evt[0] <= 1'b0;
        rdchk(rcc_pkg::RCC_OFS_CONTROL, 32'h2000_0000);
    endtask

    // All-ones write, then keep-on against sleep
    task automatic t_rw;
        wrok(rcc_pkg::RCC_OFS_CONTROL, 32'hffff_ffff);
        rdchk(rcc_pkg::RCC_OFS_CONTROL, 32'h2000_03df);
        i_sleep_mode <= 1'b1;
        repeat (2) @(negedge i_sys_clk);
        `CHK("keep_on", 1'b1, o_regulator_sleep_keep_on)
        `CHK("regulator_en", 1'b1, o_regulator_en)
        wrok(rcc_pkg::RCC_OFS_CONTROL, 32'h0000_0000);
        @(negedge i_sys_clk);
        `CHK("regulator_en", 1'b0, o_regulator_en)
        rdchk(rcc_pkg::RCC_OFS_CONTROL, 32'h0000_0000);
        i_sleep_mode <= 1'b0;
        repeat (2) @(negedge i_sys_clk);
        `CHK("regulator_en", 1'b1, o_regulator_en)
    endtask

    // Interrupt raised, masked, re-enabled and cleared
    task automatic t_irq;
        // Status still holds every earlier event; clear it first
        wrok(rcc_pkg::RCC_OFS_IRQ_CLEAR, rcc_pkg::RCC_FLAG_MASK);
        wrok(rcc_pkg::RCC_OFS_IRQ_ENABLE, rcc_pkg::RCC_FLAG_MASK);
        @(negedge i_sys_clk);
        `CHK("irq", 1'b0, o_irq)
        pulse(4);
        @(negedge i_sys_clk);
        `CHK("irq", 1'b1, o_irq)
        rdchk(rcc_pkg::RCC_OFS_IRQ_STATUS, 32'h0000_0010);
        wrok(rcc_pkg::RCC_OFS_IRQ_ENABLE, 32'h0000_0000);
        @(negedge i_sys_clk);
        `CHK("irq", 1'b0, o_irq)
        wrok(rcc_pkg::RCC_OFS_IRQ_ENABLE, rcc_pkg::RCC_FLAG_MASK);
        @(negedge i_sys_clk);
        `CHK("irq", 1'b1, o_irq)
        wrok(rcc_pkg::RCC_OFS_IRQ_CLEAR, 32'h0000_0010);
        @(negedge i_sys_clk);
        `CHK("irq", 1'b0, o_irq)
        rdchk(rcc_pkg::RCC_OFS_IRQ_STATUS, 32'h0000_0000);
        rdchk(rcc_pkg::RCC_OFS_IRQ_CLEAR, 32'h0000_0000);
    endtask

    // Unmapped offset answers with an error and reads zero
    task automatic t_unmapped;
        logic [31:0] d;
        logic [1:0] r;
        wr(12'h010, 32'hffff_ffff, r);
        `CHK("write resp", rcc_pkg::RCC_RESP_SLVERR, r)
        rd(12'h010, d, r);
        `CHK("read resp", rcc_pkg::RCC_RESP_SLVERR, r)
        `CHK("read data", 32'h0000_0000, d)
    endtask

    // Main sequence
    initial begin
        t_reset();
        t_events();
        t_rw();
        t_irq();
        t_unmapped();
        t_reset();
        summarize();
    end
endmodule

bind rcc_top rcc_top_props #(.ADDR_W(ADDR_W)) u_props (.*);
